//--- inc/serial_port_regs.svh
// Register offsets, bit positions, reset values and timing counts
// Assumes inclusion by the serial port design only
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH

// ----------------------------------------
// Register word offsets
// ----------------------------------------
`define OFF_CTRL 4'h0
`define OFF_STAT 4'h1
`define OFF_CLK_CTRL 4'h2
`define OFF_RX_DATA 4'h3
`define OFF_IRQ_STAT 4'h4
`define OFF_IRQ_MASK 4'h5
`define OFF_EVENTS 4'h6
`define OFF_ACK 4'h7

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define CTRL_RX_ERROR_IRQ_EN 16
`define CTRL_CLK_POLARITY 15
`define CTRL_TIMER_RATE_BYPASS 14
`define CTRL_TIMER_IRQ_EN 13
`define CTRL_WRITE_MASK 24'h01FFFF

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CTRL_RESET 24'h000000
`define CLK_CTRL_RESET 12'h000
`define IRQ_MASK_RESET 2'h0

// ----------------------------------------
// Timer chain
// ----------------------------------------
`define BAUD_DIV 4'hF
`define BAUD_HALF 4'h7
`define SLOW_DIV 5'h1F

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define STAT_OVERRUN 4
`define STAT_RX_FULL 2
`define STAT_FRAMING 6
`define STAT_PARITY 5

`endif

//--- inc/serial_port_pkg.sv
// Types shared by the serial port control block
// Assumes the register header is on the include path
package serial_port_pkg;

  typedef struct packed {
    logic rx_full_flag;
    logic parity_error_flag;
    logic framing_error_flag;
    logic overrun_flag;
  } rx_status_type;

  typedef struct packed {
    logic rx_exc_irq;
    logic timer_irq;
  } irq_bits_type;

  typedef enum logic [1:0] {
    rd_idle,
    rd_stat_seen
  } clear_seq_type;

endpackage : serial_port_pkg

//--- design/serial_port.sv
// Serial port control register, baud-rate timer and interrupt requests
// Assumes Avalon-MM master on clk_in; receiver status arrives as levels
//
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
`include "serial_port_regs.svh"

module serial_port
  import serial_port_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic soft_reset_in,
  // Avalon-MM slave
  input wire logic [3:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  // Receiver status
  input wire rx_status_type rx_status_in,
  input wire logic sync_mode_in,
  // Interrupt controller
  input wire logic timer_ack_in,
  output logic rx_exc_req_out,
  output logic timer_req_out,
  output logic irq_out,
  // Serial clock
  output logic serial_clk_out,
  output logic clk_polarity_out
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [23:0] ctrl;
    logic [11:0] clk_ctrl;
    logic [11:0] baud_cnt;
    logic [3:0] div16;
    logic [4:0] div32;
    logic baud_tick;
    logic timer_req;
    logic rx_exc_req;
    clear_seq_type seq;
    irq_bits_type irq_stat;
    irq_bits_type irq_mask;
    logic irq;
    logic bit_phase;
    logic serial_clk;
    logic ack_pending;
    logic [31:0] rdata;
  } state_type;

  state_type state_r;
  state_type state_nxt;
  logic acc;
  logic done;
  logic timer_event;
  logic exc_cond;
  logic soft_clear;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    acc = (read_in || write_in) && !state_r.ack_pending;
    soft_clear = soft_reset_in;
    timer_event = 1'b0;
    // Effects land only at the edge where waitrequest is seen low
    done = (read_in || write_in) && state_r.ack_pending;
    state_nxt.ack_pending = acc;
    state_nxt.rdata = 32'h00000000;
    // Baud counter and div16 free-run, independent of pin use; div32 holds while bypass is set
    state_nxt.baud_tick = 1'b0;
    if (state_r.baud_cnt == 12'h000) begin
      state_nxt.baud_cnt = state_r.clk_ctrl;
      state_nxt.baud_tick = 1'b1;
    end else begin
      state_nxt.baud_cnt = state_r.baud_cnt - 12'h001;
    end
    if (state_r.baud_tick) begin
      state_nxt.div16 = state_r.div16 + 4'h1;
      state_nxt.bit_phase = (state_r.div16 == `BAUD_HALF) ? 1'b1 :
        ((state_r.div16 == `BAUD_DIV) ? 1'b0 : state_r.bit_phase);
      if (state_r.div16 == `BAUD_DIV) begin
        if (state_r.ctrl[`CTRL_TIMER_RATE_BYPASS]) begin
          timer_event = 1'b1;
        end else begin
          state_nxt.div32 = state_r.div32 + 5'h01;
          timer_event = (state_r.div32 == `SLOW_DIV);
        end
      end
    end
    // Bypass must stay fixed while timer enabled, else divide phase is off
    if (timer_event && state_r.ctrl[`CTRL_TIMER_IRQ_EN]) begin
      state_nxt.timer_req = 1'b1;
    end else if (timer_ack_in) begin
      state_nxt.timer_req = 1'b0;
    end
    if (!state_r.ctrl[`CTRL_TIMER_IRQ_EN]) begin
      state_nxt.timer_req = 1'b0;
    end
    // Exception request and its status-then-data clearing sequence
    exc_cond = state_r.ctrl[`CTRL_RX_ERROR_IRQ_EN] && rx_status_in.rx_full_flag &&
      (rx_status_in.parity_error_flag || rx_status_in.framing_error_flag ||
      rx_status_in.overrun_flag);
    if (done && read_in && address_in == `OFF_STAT) begin
      state_nxt.seq = rd_stat_seen;
    end else if (done && read_in && address_in == `OFF_RX_DATA) begin
      state_nxt.seq = rd_idle;
    end
    if (done && read_in && address_in == `OFF_RX_DATA && state_r.seq == rd_stat_seen) begin
      state_nxt.rx_exc_req = 1'b0;
    end else begin
      state_nxt.rx_exc_req = exc_cond;
    end
    // Sticky status, set wins over write-one-to-clear
    if (done && write_in && address_in == `OFF_IRQ_STAT) begin
      state_nxt.irq_stat = state_r.irq_stat & ~irq_bits_type'(writedata_in[1:0]);
    end
    if (exc_cond) begin
      state_nxt.irq_stat.rx_exc_irq = 1'b1;
    end
    if (timer_event && state_r.ctrl[`CTRL_TIMER_IRQ_EN]) begin
      state_nxt.irq_stat.timer_irq = 1'b1;
    end
    state_nxt.irq = |(state_r.irq_stat & state_r.irq_mask);
    // Register writes
    if (done && write_in) begin
      case (address_in)
        `OFF_CTRL: state_nxt.ctrl = writedata_in[23:0] & `CTRL_WRITE_MASK;
        `OFF_CLK_CTRL: state_nxt.clk_ctrl = writedata_in[11:0];
        `OFF_IRQ_MASK: state_nxt.irq_mask = irq_bits_type'(writedata_in[1:0]);
        default: ;
      endcase
    end
    // Register reads
    if (acc && read_in) begin
      case (address_in)
        `OFF_CTRL: state_nxt.rdata = {8'h00, state_r.ctrl};
        `OFF_STAT: state_nxt.rdata = {25'h0000000, rx_status_in.framing_error_flag,
          rx_status_in.parity_error_flag, rx_status_in.overrun_flag, 1'b0,
          rx_status_in.rx_full_flag, 2'h0};
        `OFF_CLK_CTRL: state_nxt.rdata = {20'h00000, state_r.clk_ctrl};
        `OFF_RX_DATA: state_nxt.rdata = 32'h00000000;
        `OFF_IRQ_STAT: state_nxt.rdata = {30'h00000000, state_r.irq_stat};
        `OFF_IRQ_MASK: state_nxt.rdata = {30'h00000000, state_r.irq_mask};
        `OFF_EVENTS: state_nxt.rdata = {30'h00000000, state_r.rx_exc_req, state_r.timer_req};
        default: state_nxt.rdata = 32'h00000000;
      endcase
    end
    // Serial clock: polarity picks idle level and centred edge
    if (sync_mode_in) begin
      // Gated: toggles only while the transmitter is on, else idles
      state_nxt.serial_clk = !state_r.ctrl[`CTRL_CLK_POLARITY] ^ (state_r.ctrl[9] & state_r.bit_phase);
    end else begin
      state_nxt.serial_clk = state_r.ctrl[`CTRL_CLK_POLARITY] ? !state_r.bit_phase : state_r.bit_phase;
    end
    if (soft_clear) begin
      state_nxt.ctrl = `CTRL_RESET;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign readdata_out = state_r.rdata;
  assign waitrequest_out = !state_r.ack_pending;
  assign rx_exc_req_out = state_r.rx_exc_req;
  assign timer_req_out = state_r.timer_req;
  assign irq_out = state_r.irq;
  assign serial_clk_out = state_r.serial_clk;
  assign clk_polarity_out = state_r.ctrl[`CTRL_CLK_POLARITY];

endmodule : serial_port

//--- verif/serial_port_properties.sv
// Port checks for the serial port control block
// Assumes one clock domain and binding onto serial_port
`timescale 1ns/1ns
module serial_port_properties
  import serial_port_pkg::*;
(
  // Clock, reset, bus
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic soft_reset_in,
  input wire logic [3:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  input wire logic [31:0] readdata_out,
  input wire logic waitrequest_out,
  // Status and requests
  input wire rx_status_type rx_status_in,
  input wire logic sync_mode_in,
  input wire logic timer_ack_in,
  input wire logic rx_exc_req_out,
  input wire logic timer_req_out,
  input wire logic serial_clk_out,
  input wire logic clk_polarity_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  logic pol_r;
  logic wr_ctrl;
  logic rx_bad;
  assign wr_ctrl = write_in && !waitrequest_out && address_in == 4'h0;
  assign rx_bad = rx_status_in.rx_full_flag && (|rx_status_in[2:0]);
  // Copy of the last polarity written, for the output check
  always_ff @(posedge clk_in) if (wr_ctrl) pol_r <= writedata_in[15];
  sequence s_answer;
    waitrequest_out ##1 !waitrequest_out ##1 waitrequest_out;
  endsequence
  sequence s_quiet;
    (sync_mode_in && $stable(clk_polarity_out)) [*3];
  endsequence
  property p_ans; $rose(read_in || write_in) |-> s_answer; endproperty
  a_ans: assert property (p_ans) else $error("bus answer late");
  property p_resv; read_in && !waitrequest_out && address_in == 4'h0 |-> readdata_out[31:17] == 15'h0000; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  property p_pol; wr_ctrl |-> ##2 clk_polarity_out == pol_r; endproperty
  a_pol: assert property (p_pol) else $error("polarity not written");
  property p_soft; soft_reset_in |-> ##2 !clk_polarity_out; endproperty
  a_soft: assert property (p_soft) else $error("soft reset kept polarity");
  property p_rxexc; rx_exc_req_out |-> $past(rx_bad); endproperty
  a_rxexc: assert property (p_rxexc) else $error("exception without cause");
  property p_ack; timer_ack_in |=> !timer_req_out; endproperty
  a_ack: assert property (p_ack) else $error("timer request kept");
  property p_idle; s_quiet |-> serial_clk_out != clk_polarity_out; endproperty
  a_idle: assert property (p_idle) else $error("wrong idle clock level");
  property p_rst; disable iff (1'b0) !reset_n_in |=> waitrequest_out && !timer_req_out; endproperty
  a_rst: assert property (p_rst) else $error("outputs not reset");
endmodule : serial_port_properties
bind serial_port serial_port_properties u_props (.*);

//--- verif/serial_port_partner.sv
// Interrupt controller side of the timer request
// Assumes the clock of the serial port
`timescale 1ns/1ns
module serial_port_partner (
  // Clock
  input wire logic clk_in,
  // Handshake
  input wire logic req_in,
  output logic ack_out
);
  // Never two in a row, so one request is taken once
  always @(posedge clk_in) begin
    ack_out <= req_in && (ack_out !== 1'b1);
  end
endmodule : serial_port_partner

//--- verif/tb_serial_port.sv
// Bench for the serial port control block
// Assumes package, header, design and checker compiled first
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; $display("ERROR %0t %h %h", $time, a, b); end end
module tb_serial_port import serial_port_pkg::*;;
  logic clk_in = 1'b0, reset_n_in = 1'b0, soft_reset_in = 1'b0, read_in = 1'b0, write_in = 1'b0;
  logic sync_mode_in = 1'b1;
  logic [3:0] address_in = 4'h0;
  logic [31:0] writedata_in = 32'h00000000;
  rx_status_type rx_status_in = 4'h0;
  logic [31:0] readdata_out, q;
  logic waitrequest_out, timer_ack_in, rx_exc_req_out, timer_req_out, irq_out, serial_clk_out, clk_polarity_out;
  int c, compares = 0, miscompares = 0;
  serial_port dut (.*);
  serial_port_partner peer (.clk_in(clk_in), .req_in(timer_req_out), .ack_out(timer_ack_in));
  initial forever #4 clk_in = ~clk_in;
  initial begin #200000; miscompares++; test_done(); end
  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  // Held until waitrequest is seen low, then one idle edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    address_in <= a;
    writedata_in <= d;
    write_in <= w;
    read_in <= !w;
    do @(posedge clk_in); while (waitrequest_out !== 1'b0);
    q = readdata_out;
    write_in <= 1'b0;
    read_in <= 1'b0;
    @(posedge clk_in);
  endtask : bus
  // Cycles between two rising timer requests
  task automatic gap();
    while (timer_req_out !== 1'b1) @(posedge clk_in);
    c = 0;
    do begin @(posedge clk_in); c++; end while (timer_req_out === 1'b1);
    while (timer_req_out !== 1'b1) begin @(posedge clk_in); c++; end
  endtask : gap
  initial begin
    repeat (20) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    bus(1'b0, 4'h0, 32'h0);
    `CHK(q, 32'h00000000)
    `CHK(serial_clk_out, 1'b1)
    bus(1'b1, 4'h0, 32'hFFFFFCFF);
    bus(1'b0, 4'h0, 32'h0);
    `CHK(q, 32'h0001FCFF)
    `CHK(serial_clk_out, 1'b0)
    soft_reset_in <= 1'b1;
    @(posedge clk_in);
    soft_reset_in <= 1'b0;
    bus(1'b0, 4'h0, 32'h0);
    `CHK(q[16:13], 4'h0)
    bus(1'b1, 4'hF, 32'hFFFFFFFF);
    bus(1'b0, 4'hF, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b1, 4'h0, 32'h00010000);
    for (int i = 0; i < 4; i++) begin
      rx_status_in <= 4'h8 | (4'h1 << i);
      repeat (3) @(posedge clk_in);
      `CHK(rx_exc_req_out, i < 3)
    end
    rx_status_in <= 4'hA;
    repeat (3) @(posedge clk_in);
    `CHK(rx_exc_req_out, 1'b1)
    bus(1'b0, 4'h1, 32'h0);
    bus(1'b0, 4'h3, 32'h0);
    `CHK(rx_exc_req_out, 1'b0)
    bus(1'b1, 4'h0, 32'h0);
    @(posedge clk_in);
    `CHK(rx_exc_req_out, 1'b0)
    rx_status_in <= 4'h0;
    bus(1'b1, 4'h2, 32'h0);
    bus(1'b1, 4'h5, 32'h1);
    bus(1'b1, 4'h0, 32'h00006000);
    gap();
    `CHK(c, 16)
    `CHK(irq_out, 1'b1)
    bus(1'b1, 4'h0, 32'h0);
    bus(1'b1, 4'h4, 32'h3);
    bus(1'b0, 4'h4, 32'h0);
    `CHK(q, 32'h0)
    `CHK(irq_out, 1'b0)
    bus(1'b1, 4'h0, 32'h00002000);
    gap();
    `CHK(c, 512)
    bus(1'b1, 4'h5, 32'h0);
    bus(1'b1, 4'h0, 32'h0);
    bus(1'b0, 4'h4, 32'h0);
    `CHK(q, 32'h1)
    `CHK(irq_out, 1'b0)
    test_done();
  end
endmodule : tb_serial_port
